// *** osa_map.vh ***
`ifndef OSA_MAP_VH
`define OSA_MAP_VH
// register indices on the configuration port
`define OSA_REG_SRC_SEL     16'h0fc8
`define OSA_REG_OVF_EN      16'h0fc9
`define OSA_REG_SC_IN_LO    16'h1dba
`define OSA_REG_SC_IN_HI    16'h1dbb
`define OSA_REG_SC_OUT_LO   16'h1dbc
`define OSA_REG_SC_OUT_HI   16'h1dbd
`define OSA_REG_OV_IN_LO    16'h1df0
`define OSA_REG_OV_IN_HI    16'h1df1
`define OSA_REG_OV_OUT_LO   16'h1df2
`define OSA_REG_OV_OUT_HI   16'h1df3
`define OSA_REG_AL1_MODE    16'h1e00
`define OSA_REG_AL1_LO      16'h1e01
`define OSA_REG_AL1_HI      16'h1e02
`define OSA_REG_AL2_MODE    16'h1e03
`define OSA_REG_AL2_LO      16'h1e04
`define OSA_REG_AL2_HI      16'h1e05
`define OSA_REG_STATUS      16'h1e06
// source codes
`define OSA_SRC_DISP        2'h0
`define OSA_SRC_DISP2       2'h1
`define OSA_SRC_CLOCK       2'h2
// alarm modes
`define OSA_AM_WIN_ON       3'h0
`define OSA_AM_WIN_OFF      3'h1
`define OSA_AM_ON           3'h2
`define OSA_AM_OFF          3'h3
`define OSA_AM_FORCE_ON     3'h4
`define OSA_AM_FORCE_OFF    3'h5
// reset values
`define OSA_RST_OVF_EN      1'h0
`define OSA_RST_MODE        3'h5
`define OSA_RST_ZERO        16'h0000
`define OSA_RST_SC_IN_HI    16'h03e8
`define OSA_RST_SC_OUT_HI   16'h0014
// clock scaling: hours * 100 + minutes
`define OSA_HOUR_WEIGHT     16'h0064
`define OSA_LAST_HOUR       5'h17
`define OSA_LAST_MIN        6'h3b
`endif

// *** osa_output_scaling_alarms.v ***
`include "osa_map.vh"
module osa_output_scaling_alarms #(
  parameter W = 16
) (
  input  wire          i_clk_sys,
  input  wire          i_rst,
  input  wire          i_reg_wr,
  input  wire          i_reg_rd,
  input  wire [15:0]   i_reg_addr,
  input  wire [W-1:0]  i_reg_wdata,
  output reg  [W-1:0]  o_reg_rdata,
  output reg           o_reg_ack,
  input  wire [W-1:0]  i_disp_val,
  input  wire [W-1:0]  i_disp2_val,
  input  wire [4:0]    i_rtc_hour,
  input  wire [5:0]    i_rtc_min,
  input  wire [W-1:0]  i_alarm_val,
  input  wire          i_aux_supply_variant,
  output reg  [W-1:0]  o_aout_setpoint,
  output reg           o_ovf_upper,
  output reg           o_ovf_lower,
  output reg           o_relay1,
  output reg           o_relay2,
  output reg           o_aux_supply
);
  // ***************************************************************
  // registers
  // ***************************************************************
  reg [1:0]   src_sel_q;
  reg         ovf_en_q;
  reg [W-1:0] sc_in_lo_q, sc_in_hi_q, sc_out_lo_q, sc_out_hi_q;
  reg [W-1:0] ov_in_lo_q, ov_in_hi_q, ov_out_lo_q, ov_out_hi_q;
  reg [2:0]   mode_q [0:1];
  reg [W-1:0] al_lo_q [0:1];
  reg [W-1:0] al_hi_q [0:1];
  wire [1:0]  alarm_q;

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      src_sel_q   <= `OSA_SRC_DISP;
      ovf_en_q    <= `OSA_RST_OVF_EN;
      sc_in_lo_q  <= `OSA_RST_ZERO;
      sc_in_hi_q  <= `OSA_RST_SC_IN_HI;
      sc_out_lo_q <= `OSA_RST_ZERO;
      sc_out_hi_q <= `OSA_RST_SC_OUT_HI;
      ov_in_lo_q  <= `OSA_RST_ZERO;
      ov_in_hi_q  <= `OSA_RST_ZERO;
      ov_out_lo_q <= `OSA_RST_ZERO;
      ov_out_hi_q <= `OSA_RST_ZERO;
      mode_q[0]   <= `OSA_RST_MODE;
      mode_q[1]   <= `OSA_RST_MODE;
      al_lo_q[0]  <= `OSA_RST_ZERO;
      al_lo_q[1]  <= `OSA_RST_ZERO;
      al_hi_q[0]  <= `OSA_RST_ZERO;
      al_hi_q[1]  <= `OSA_RST_ZERO;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `OSA_REG_SRC_SEL:   src_sel_q   <= i_reg_wdata[1:0];
        `OSA_REG_OVF_EN:    ovf_en_q    <= i_reg_wdata[0];
        `OSA_REG_SC_IN_LO:  sc_in_lo_q  <= i_reg_wdata;
        `OSA_REG_SC_IN_HI:  sc_in_hi_q  <= i_reg_wdata;
        `OSA_REG_SC_OUT_LO: sc_out_lo_q <= i_reg_wdata;
        `OSA_REG_SC_OUT_HI: sc_out_hi_q <= i_reg_wdata;
        `OSA_REG_OV_IN_LO:  ov_in_lo_q  <= i_reg_wdata;
        `OSA_REG_OV_IN_HI:  ov_in_hi_q  <= i_reg_wdata;
        `OSA_REG_OV_OUT_LO: ov_out_lo_q <= i_reg_wdata;
        `OSA_REG_OV_OUT_HI: ov_out_hi_q <= i_reg_wdata;
        `OSA_REG_AL1_MODE:  mode_q[0]   <= i_reg_wdata[2:0];
        `OSA_REG_AL1_LO:    al_lo_q[0]  <= i_reg_wdata;
        `OSA_REG_AL1_HI:    al_hi_q[0]  <= i_reg_wdata;
        `OSA_REG_AL2_MODE:  mode_q[1]   <= i_reg_wdata[2:0];
        `OSA_REG_AL2_LO:    al_lo_q[1]  <= i_reg_wdata;
        `OSA_REG_AL2_HI:    al_hi_q[1]  <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // register read port
  // ***************************************************************
  reg [W-1:0] rdata_d;
  always @* begin
    case (i_reg_addr)
      `OSA_REG_SRC_SEL:   rdata_d = {{(W-2){1'b0}}, src_sel_q};
      `OSA_REG_OVF_EN:    rdata_d = {{(W-1){1'b0}}, ovf_en_q};
      `OSA_REG_SC_IN_LO:  rdata_d = sc_in_lo_q;
      `OSA_REG_SC_IN_HI:  rdata_d = sc_in_hi_q;
      `OSA_REG_SC_OUT_LO: rdata_d = sc_out_lo_q;
      `OSA_REG_SC_OUT_HI: rdata_d = sc_out_hi_q;
      `OSA_REG_OV_IN_LO:  rdata_d = ov_in_lo_q;
      `OSA_REG_OV_IN_HI:  rdata_d = ov_in_hi_q;
      `OSA_REG_OV_OUT_LO: rdata_d = ov_out_lo_q;
      `OSA_REG_OV_OUT_HI: rdata_d = ov_out_hi_q;
      `OSA_REG_AL1_MODE:  rdata_d = {{(W-3){1'b0}}, mode_q[0]};
      `OSA_REG_AL1_LO:    rdata_d = al_lo_q[0];
      `OSA_REG_AL1_HI:    rdata_d = al_hi_q[0];
      `OSA_REG_AL2_MODE:  rdata_d = {{(W-3){1'b0}}, mode_q[1]};
      `OSA_REG_AL2_LO:    rdata_d = al_lo_q[1];
      `OSA_REG_AL2_HI:    rdata_d = al_hi_q[1];
      `OSA_REG_STATUS:    rdata_d = {{(W-4){1'b0}}, o_ovf_upper, o_ovf_lower, alarm_q};
      default:            rdata_d = {W{1'b0}};
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_rdata <= {W{1'b0}};
      o_reg_ack   <= 1'b0;
    end else begin
      o_reg_rdata <= i_reg_rd ? rdata_d : {W{1'b0}};
      o_reg_ack   <= i_reg_rd | i_reg_wr;
    end
  end

  // ***************************************************************
  // source selection and linear characteristic
  // ***************************************************************
  wire [W-1:0] clk_val = i_rtc_hour * `OSA_HOUR_WEIGHT + i_rtc_min;
  reg  [W-1:0] src_d;
  always @* begin
    case (src_sel_q)
      `OSA_SRC_DISP:  src_d = i_disp_val;
      `OSA_SRC_DISP2: src_d = i_disp2_val;
      `OSA_SRC_CLOCK: src_d = clk_val;
      default:        src_d = i_disp_val;
    endcase
  end

  // out = yl + (x - xl) * (yh - yl) / (xh - xl), signed arithmetic
  wire signed [W:0]     dx   = $signed({1'b0, src_d}) - $signed({1'b0, sc_in_lo_q});
  wire signed [W:0]     dy   = $signed({1'b0, sc_out_hi_q}) - $signed({1'b0, sc_out_lo_q});
  wire signed [W:0]     span = $signed({1'b0, sc_in_hi_q}) - $signed({1'b0, sc_in_lo_q});
  // operands widened first so product and quotient keep their sign; an unsigned
  // zero arm in the select would turn the whole division unsigned
  wire signed [2*W+1:0] dx_x   = {{(W+1){dx[W]}}, dx};
  wire signed [2*W+1:0] dy_x   = {{(W+1){dy[W]}}, dy};
  wire signed [2*W+1:0] span_x = {{(W+1){span[W]}}, span};
  wire signed [2*W+1:0] prod   = dx_x * dy_x;
  wire signed [2*W+1:0] quo    = (~|span) ? $signed({(2*W+2){1'b0}}) : prod / span_x;
  wire signed [2*W+1:0] lin  = quo + $signed({{(W+2){1'b0}}, sc_out_lo_q});

  wire ovf_hi = src_d > ov_in_hi_q;
  wire ovf_lo = src_d < ov_in_lo_q;

  reg [W-1:0] aout_d;
  always @* begin
    if (ovf_en_q && ovf_hi)
      aout_d = ov_out_hi_q;
    else if (ovf_en_q && ovf_lo)
      aout_d = ov_out_lo_q;
    else
      aout_d = lin[W-1:0];
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_aout_setpoint <= {W{1'b0}};
      o_ovf_upper     <= 1'b0;
      o_ovf_lower     <= 1'b0;
    end else begin
      o_aout_setpoint <= aout_d;
      o_ovf_upper     <= ovf_en_q & ovf_hi;
      o_ovf_lower     <= ovf_en_q & ovf_lo & ~ovf_hi;
    end
  end

  // ***************************************************************
  // alarm channels
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_alarm
      wire bad = al_lo_q[g] > al_hi_q[g];
      wire above = i_alarm_val > al_hi_q[g];
      wire below = i_alarm_val < al_lo_q[g];
      reg  nxt;
      reg  state_q;
      assign alarm_q[g] = state_q;
      always @* begin
        case (mode_q[g])
          `OSA_AM_FORCE_ON:  nxt = 1'b1;
          `OSA_AM_FORCE_OFF: nxt = 1'b0;
          `OSA_AM_WIN_ON:    nxt = ~bad & ~above & ~below;
          `OSA_AM_WIN_OFF:   nxt = ~bad & (above | below);
          `OSA_AM_ON:        nxt = ~bad & (above | (alarm_q[g] & ~below));
          `OSA_AM_OFF:       nxt = ~bad & (below | (alarm_q[g] & ~above));
          default:           nxt = 1'b0;
        endcase
      end
      always @(posedge i_clk_sys) begin
        if (i_rst)
          state_q <= 1'b0;
        else
          state_q <= nxt;
      end
    end
  endgenerate

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_relay1     <= 1'b0;
      o_relay2     <= 1'b0;
      o_aux_supply <= 1'b0;
    end else begin
      o_relay1     <= alarm_q[0];
      o_relay2     <= alarm_q[1] & ~i_aux_supply_variant;
      o_aux_supply <= alarm_q[1] & i_aux_supply_variant;
    end
  end
endmodule // osa_output_scaling_alarms

// *** osa_checker_sva.sv ***
// ****************************************
// port checker
// ****************************************
module osa_checker (
  input wire        i_clk_sys,
  input wire        i_rst,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [15:0] o_reg_rdata,
  input wire        o_reg_ack,
  input wire [15:0] i_disp_val,
  input wire [15:0] i_disp2_val,
  input wire [4:0]  i_rtc_hour,
  input wire [5:0]  i_rtc_min,
  input wire        i_aux_supply_variant,
  input wire [15:0] o_aout_setpoint,
  input wire        o_ovf_upper,
  input wire        o_ovf_lower,
  input wire        o_relay1,
  input wire        o_relay2,
  input wire        o_aux_supply
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  rst_clear_a: assert property ($fell(i_rst) |-> !o_reg_ack && !o_relay1 && !o_relay2
    && !o_aux_supply && o_aout_setpoint == 16'h0000) else $error("outputs not clear after reset");
  ack_after_access_a: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack) else $error("ack missing");
  ack_only_access_a: assert property (o_reg_ack |-> $past(i_reg_wr || i_reg_rd)) else $error("stray ack");
  rdata_idle_zero_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 16'h0000) else $error("rdata not zero");
  ovf_flags_exclusive_a: assert property (!(o_ovf_upper && o_ovf_lower)) else $error("both ovf flags");
  relay2_variant_off_a: assert property (i_aux_supply_variant [*3] |-> !o_relay2) else $error("relay2 on");
  aux_variant_off_a: assert property (!i_aux_supply_variant [*3] |-> !o_aux_supply) else $error("aux on");
  setpoint_steady_a: assert property (!$past(i_reg_wr) && !$past(i_rst) && $stable(i_disp_val)
    && $stable(i_disp2_val) && $stable(i_rtc_hour) && $stable(i_rtc_min)
    |=> $stable(o_aout_setpoint) && $stable(o_ovf_upper)) else $error("setpoint moved");
endmodule // osa_checker
bind osa_output_scaling_alarms osa_checker i_osa_checker (.*);

// *** testbench.sv ***
`include "osa_map.vh"
// ****************************************
// register and datapath scenarios
// ****************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, var_aux = 1'b0;
  reg [15:0] addr = 16'h0000, wdata = 16'h0000, disp = 16'h0000, disp2 = 16'h0000, aval = 16'h0000;
  reg [4:0]  hour = 5'h00;
  reg [5:0]  mins = 6'h00;
  wire [15:0] rdata, sp;
  wire       ack, ovu, ovl, rl1, rl2, aux;
  integer    failures = 0, checked = 0, i;
  osa_output_scaling_alarms i_osa_output_scaling_alarms (.i_clk_sys(clk), .i_rst(rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_disp_val(disp), .i_disp2_val(disp2), .i_rtc_hour(hour), .i_rtc_min(mins), .i_alarm_val(aval),
    .i_aux_supply_variant(var_aux), .o_aout_setpoint(sp), .o_ovf_upper(ovu), .o_ovf_lower(ovl),
    .o_relay1(rl1), .o_relay2(rl2), .o_aux_supply(aux));
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input string nm, input [15:0] e, input [15:0] g);
    checked = checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr_reg(input [15:0] a, input [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [15:0] a, input [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("ack", 16'h0001, {15'h0000, ack});
    chk("rdata", e, rdata);
  endtask
  task out_chk(input [15:0] e, input eu, input el);
    repeat (3) @(posedge clk);
    #1;
    chk("setpoint", e, sp);
    chk("ovf", {14'h0000, eu, el}, {14'h0000, ovu, ovl});
    @(posedge clk);
  endtask
  task al(input [2:0] m, input [15:0] v, input e);
    wr_reg(`OSA_REG_AL1_MODE, {13'h0000, m});
    @(posedge clk);
    aval <= v;
    repeat (3) @(posedge clk);
    #1;
    chk("relay1", {15'h0000, e}, {15'h0000, rl1});
  endtask
  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OSA_REG_OVF_EN, 16'h0000);
    rd_chk(`OSA_REG_SC_IN_HI, 16'h03e8);
    rd_chk(`OSA_REG_AL1_MODE, 16'h0005);
    wr_reg(16'h0123, 16'hffff);
    rd_chk(16'h0123, 16'h0000);
    wr_reg(`OSA_REG_SC_OUT_LO, 16'h0004);
    disp <= 16'h01f4;
    out_chk(16'h000c, 1'b0, 1'b0);
    disp <= 16'h05dc;
    out_chk(16'h001c, 1'b0, 1'b0);
    wr_reg(`OSA_REG_OV_OUT_LO, 16'h0001);
    wr_reg(`OSA_REG_OV_OUT_HI, 16'h0003);
    wr_reg(`OSA_REG_OV_IN_HI, 16'h03e8);
    wr_reg(`OSA_REG_OVF_EN, 16'h0001);
    out_chk(16'h0003, 1'b1, 1'b0);
    wr_reg(`OSA_REG_OV_IN_LO, 16'h0064);
    disp <= 16'h0032;
    out_chk(16'h0001, 1'b0, 1'b1);
    disp2 <= 16'h00fa;
    wr_reg(`OSA_REG_SRC_SEL, 16'h0001);
    out_chk(16'h0008, 1'b0, 1'b0);
    wr_reg(`OSA_REG_OVF_EN, 16'h0000);
    wr_reg(`OSA_REG_SC_IN_HI, 16'h0937);
    hour <= 5'h17;
    mins <= 6'h3b;
    wr_reg(`OSA_REG_SRC_SEL, 16'h0002);
    out_chk(16'h0014, 1'b0, 1'b0);
    hour <= 5'h0c;
    mins <= 6'h00;
    out_chk(16'h000c, 1'b0, 1'b0);
    wr_reg(`OSA_REG_AL1_LO, 16'h0064);
    wr_reg(`OSA_REG_AL1_HI, 16'h00c8);
    al(`OSA_AM_ON, 16'h00fa, 1'b1);
    al(`OSA_AM_ON, 16'h0096, 1'b1);
    al(`OSA_AM_ON, 16'h0032, 1'b0);
    al(`OSA_AM_OFF, 16'h0032, 1'b1);
    al(`OSA_AM_WIN_ON, 16'h0096, 1'b1);
    al(`OSA_AM_WIN_OFF, 16'h0096, 1'b0);
    al(`OSA_AM_WIN_ON, 16'h00fa, 1'b0);
    al(`OSA_AM_FORCE_ON, 16'h0032, 1'b1);
    al(`OSA_AM_FORCE_OFF, 16'h0096, 1'b0);
    wr_reg(`OSA_REG_AL1_LO, 16'h012c);
    al(`OSA_AM_WIN_OFF, 16'h00fa, 1'b0);
    al(`OSA_AM_ON, 16'h00fa, 1'b0);
    al(`OSA_AM_FORCE_ON, 16'h0032, 1'b1);
    al(3'h6, 16'h0032, 1'b0);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      var_aux <= i[0];
      wr_reg(`OSA_REG_AL2_MODE, {13'h0000, `OSA_AM_FORCE_ON});
      repeat (3) @(posedge clk);
      #1;
      chk("relay2", {15'h0000, !i[0]}, {15'h0000, rl2});
      chk("aux", {15'h0000, i[0]}, {15'h0000, aux});
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`OSA_REG_SRC_SEL, 16'h0000);
    rd_chk(`OSA_REG_AL2_MODE, 16'h0005);
    chk("aux", 16'h0000, {15'h0000, aux});
    wr_reg(`OSA_REG_SC_IN_LO, 16'h00c8);
    wr_reg(`OSA_REG_SRC_SEL, 16'h0003);
    disp <= 16'h0028;
    out_chk(16'hfffc, 1'b0, 1'b0);
    end_sim;
  end
endmodule // testbench
